// ===== rtl/pwm_fault_steer_params.svh
/*
  Constants for the PWM output steering and fault override stage:
  register word addresses, reset values, field codes and widths.
  Assumes it is included by the package, the design module and the bench.
*/
// How it works
// - Normal mode: limit drives limit state bits
// - Independent mode ignores limit state bits
// - Exchange bit swaps high and low signals
// - Synced override data waits for period start
// - Unsynced override data applies next clock
// - State bits are logical, polarity applied after
// - 13-bit compare raises trigger on local match
// - Compare register low three bits read zero
// - Independent: limit sets high, fault sets low
// - Five-bit limit source, code 11111 reserved
// - Override enable drives pin from level bit
// - Polarity bit set makes pin active low
// - Normal mode: fault drives fault state bits
`ifndef PWM_FAULT_STEER_PARAMS_SVH
`define PWM_FAULT_STEER_PARAMS_SVH

`define PFS_ADDR_W         2
`define PFS_DATA_W         16
`define PFS_ADDR_PIN       2'h0
`define PFS_ADDR_TRIG      2'h1
`define PFS_ADDR_FAULT     2'h2

`define PFS_PIN_RESET      16'hc000
`define PFS_TRIG_RESET     13'h0000
`define PFS_FAULT_RESET    16'h00f8

`define PFS_TRIG_LSB       3
`define PFS_TRIG_W         13
`define PFS_SRC_W          5
`define PFS_SRC_RESERVED   5'h1f
`define PFS_FMODE_OFF      2'h3

`endif

// ===== rtl/pwm_fault_steer_pkg.sv
/*
  Types for the PWM output steering stage: register layouts,
  the software bus request and the live override state.
  Assumes the constants header sits beside it in rtl/.
*/
`include "pwm_fault_steer_params.svh"

package pwm_fault_steer_pkg;

  typedef struct packed {
    logic       high_owned;
    logic       low_owned;
    logic       high_pin_polarity;
    logic       low_pin_polarity;
    logic [1:0] pin_pair_mode;
    logic       high_override_enable;
    logic       low_override_enable;
    logic [1:0] override_level_bits;
    logic [1:0] fault_state_bits;
    logic [1:0] limit_state_bits;
    logic       swap;
    logic       override_sync_select;
  } pin_ctrl_s;

  typedef struct packed {
    logic                  independent_fault_select;
    logic [`PFS_SRC_W-1:0] limit_source_select;
    logic                  limit_input_polarity;
    logic                  limit_response_enable;
    logic [`PFS_SRC_W-1:0] fault_source_select;
    logic                  fault_input_polarity;
    logic [1:0]            fault_response_mode;
  } fault_ctrl_s;

  typedef struct packed {
    logic [`PFS_ADDR_W-1:0] addr;
    logic [`PFS_DATA_W-1:0] wdata;
    logic                   wr;
    logic                   rd;
  } reg_req_s;

  typedef struct packed {
    logic       high_en;
    logic       low_en;
    logic [1:0] level;
  } ovr_live_s;

endpackage

// ===== rtl/pwm_output_fault_steering.sv
/*
  Output steering stage of one PWM generator: exchange, software
  override, current-limit and fault override states, pin polarity,
  ADC trigger compare and control source selection.
  Assumes one clock, inputs synchronous to it, and a generator and
  time base that sit outside this block.
*/
// The address map and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "pwm_fault_steer_params.svh"

module pwm_output_fault_steering
  import pwm_fault_steer_pkg::*;
#(
  parameter int SRC_N = 32
) (
  // Clock, reset and enable
  input  wire logic                    i_clk,
  input  wire logic                    i_resetn,
  input  wire logic                    i_ce,
  // Register port
  input  wire reg_req_s                i_req,
  output logic [`PFS_DATA_W-1:0]       o_rdata,
  // Generator and time base
  input  wire logic                    i_gen_high,
  input  wire logic                    i_gen_low,
  input  wire logic                    i_period_start,
  input  wire logic                    i_local_timebase,
  input  wire logic [`PFS_TRIG_W-1:0]  i_timebase_count,
  input  wire logic                    i_module_enable,
  // Comparator and fault sources
  input  wire logic [SRC_N-1:0]        i_ctrl_src,
  // Pins and status
  output logic                         o_high_side_output,
  output logic                         o_low_side_output,
  output logic                         o_high_owned,
  output logic                         o_low_owned,
  output logic                         o_adc_trigger,
  output logic                         o_fault_active,
  output logic                         o_limit_active
);

  pin_ctrl_s                pin_ctrl_reg;
  fault_ctrl_s              fault_ctrl_reg;
  logic [`PFS_TRIG_W-1:0]   trigger_match_value;
  ovr_live_s                ovr_live_reg;
  ovr_live_s                ovr_live_next;
  logic [`PFS_DATA_W-1:0]   rdata_next;
  logic                     limit_in;
  logic                     fault_in;
  logic                     limit_act;
  logic                     fault_act;
  logic                     high_sw;
  logic                     low_sw;
  logic                     high_state;
  logic                     low_state;
  logic                     trig_hit;

  // Software writes
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pin_ctrl_reg <= `PFS_PIN_RESET;
    end else if (i_ce && i_req.wr && i_req.addr == `PFS_ADDR_PIN) begin
      pin_ctrl_reg <= i_req.wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      fault_ctrl_reg <= `PFS_FAULT_RESET;
    end else if (i_ce && i_req.wr && i_req.addr == `PFS_ADDR_FAULT) begin
      fault_ctrl_reg <= i_req.wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      trigger_match_value <= `PFS_TRIG_RESET;
    end else if (i_ce && i_req.wr && i_req.addr == `PFS_ADDR_TRIG) begin
      trigger_match_value <= i_req.wdata[`PFS_DATA_W-1:`PFS_TRIG_LSB];
    end
  end

  // Read data, one cycle after the strobe; unmapped reads return zero
  always_comb begin
    rdata_next = '0;
    case (i_req.addr)
      `PFS_ADDR_PIN:   rdata_next = pin_ctrl_reg;
      `PFS_ADDR_TRIG:  rdata_next = {trigger_match_value, 3'h0};
      `PFS_ADDR_FAULT: rdata_next = fault_ctrl_reg;
      default:         rdata_next = '0;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= '0;
    end else if (i_ce) begin
      o_rdata <= i_req.rd ? rdata_next : '0;
    end
  end

  // Override state that actually reaches the pins
  always_comb begin
    ovr_live_next = ovr_live_reg;
    if (!pin_ctrl_reg.override_sync_select || i_period_start) begin
      ovr_live_next.high_en = pin_ctrl_reg.high_override_enable;
      ovr_live_next.low_en  = pin_ctrl_reg.low_override_enable;
      ovr_live_next.level   = pin_ctrl_reg.override_level_bits;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ovr_live_reg <= '0;
    end else if (i_ce) begin
      ovr_live_reg <= ovr_live_next;
    end
  end

  // Control sources; the reserved code selects nothing
  always_comb begin
    limit_in = 1'b0;
    fault_in = 1'b0;
    if (fault_ctrl_reg.limit_source_select != `PFS_SRC_RESERVED) begin
      limit_in = i_ctrl_src[fault_ctrl_reg.limit_source_select] ^
                 fault_ctrl_reg.limit_input_polarity;
    end
    if (fault_ctrl_reg.fault_source_select != `PFS_SRC_RESERVED) begin
      fault_in = i_ctrl_src[fault_ctrl_reg.fault_source_select] ^
                 fault_ctrl_reg.fault_input_polarity;
    end
  end

  assign limit_act = limit_in && fault_ctrl_reg.limit_response_enable;
  assign fault_act = fault_in &&
    (fault_ctrl_reg.fault_response_mode != `PFS_FMODE_OFF);

  // Active/inactive states, priority from generator up to fault
  always_comb begin
    high_sw = pin_ctrl_reg.swap ? i_gen_low : i_gen_high;
    low_sw  = pin_ctrl_reg.swap ? i_gen_high : i_gen_low;
    high_state = ovr_live_reg.high_en ? ovr_live_reg.level[1] : high_sw;
    low_state  = ovr_live_reg.low_en ? ovr_live_reg.level[0] : low_sw;
    if (fault_ctrl_reg.independent_fault_select) begin
      // Limit bits take no part in this mode
      if (limit_act) begin
        high_state = pin_ctrl_reg.fault_state_bits[1];
      end
      if (fault_act) begin
        low_state = pin_ctrl_reg.fault_state_bits[0];
      end
    end else if (fault_act) begin
      high_state = pin_ctrl_reg.fault_state_bits[1];
      low_state  = pin_ctrl_reg.fault_state_bits[0];
    end else if (limit_act) begin
      high_state = pin_ctrl_reg.limit_state_bits[1];
      low_state  = pin_ctrl_reg.limit_state_bits[0];
    end
  end

  // Polarity is applied last to turn states into pin levels
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_high_side_output <= 1'b0;
      o_low_side_output  <= 1'b0;
    end else if (i_ce) begin
      o_high_side_output <= high_state ^
                            pin_ctrl_reg.high_pin_polarity;
      o_low_side_output  <= low_state ^
                            pin_ctrl_reg.low_pin_polarity;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_fault_active <= 1'b0;
      o_limit_active <= 1'b0;
    end else if (i_ce) begin
      o_fault_active <= fault_act;
      o_limit_active <= limit_act;
    end
  end

  assign o_high_owned = pin_ctrl_reg.high_owned;
  assign o_low_owned  = pin_ctrl_reg.low_owned;

  // ADC trigger on a local time base match, gated by the module enable
  assign trig_hit = i_local_timebase && i_module_enable &&
                    (i_timebase_count == trigger_match_value);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_adc_trigger <= 1'b0;
    end else if (i_ce) begin
      o_adc_trigger <= trig_hit;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  a_swap_route: assert property (
    i_ce && !fault_act && !limit_act && !ovr_live_reg.high_en &&
    pin_ctrl_reg.swap
    |=> o_high_side_output ==
        ($past(i_gen_low) ^ $past(pin_ctrl_reg.high_pin_polarity)))
    else $error("exchanged low signal missing on high pin");

  a_limit_normal: assert property (
    i_ce && limit_act && !fault_act &&
    !fault_ctrl_reg.independent_fault_select
    |=> o_low_side_output ==
        ($past(pin_ctrl_reg.limit_state_bits[0]) ^
         $past(pin_ctrl_reg.low_pin_polarity)))
    else $error("limit state not on low pin");

  a_indep_limit: assert property (
    i_ce && limit_act && fault_ctrl_reg.independent_fault_select
    |=> o_high_side_output ==
        ($past(pin_ctrl_reg.fault_state_bits[1]) ^
         $past(pin_ctrl_reg.high_pin_polarity)))
    else $error("independent limit did not force high pin");

  a_indep_ignore: assert property (
    i_ce && limit_act && !fault_act &&
    fault_ctrl_reg.independent_fault_select && !ovr_live_reg.low_en
    |=> o_low_side_output ==
        ($past(low_sw) ^ $past(pin_ctrl_reg.low_pin_polarity)))
    else $error("limit state leaked in independent mode");

  a_fault_prio: assert property (
    i_ce && fault_act && !fault_ctrl_reg.independent_fault_select
    |=> o_high_side_output ==
        ($past(pin_ctrl_reg.fault_state_bits[1]) ^
         $past(pin_ctrl_reg.high_pin_polarity)))
    else $error("fault state lost priority");

  a_override_drive: assert property (
    i_ce && ovr_live_reg.low_en && !fault_act && !limit_act
    |=> o_low_side_output ==
        ($past(ovr_live_reg.level[0]) ^
         $past(pin_ctrl_reg.low_pin_polarity)))
    else $error("override level not on low pin");

  a_override_sync: assert property (
    i_ce && pin_ctrl_reg.override_sync_select && !i_period_start
    |=> $stable(ovr_live_reg))
    else $error("synced override changed off period start");

  a_override_now: assert property (
    i_ce && !pin_ctrl_reg.override_sync_select
    |=> ovr_live_reg.level == $past(pin_ctrl_reg.override_level_bits))
    else $error("unsynced override not applied next clock");

  a_trig_low_zero: assert property (
    i_ce && i_req.rd && i_req.addr == `PFS_ADDR_TRIG
    |=> o_rdata[2:0] == 3'h0 &&
        o_rdata[15:3] == $past(trigger_match_value))
    else $error("trigger compare readback wrong");

  a_trig_match: assert property (
    i_ce && i_local_timebase && i_module_enable &&
    i_timebase_count == trigger_match_value
    |=> o_adc_trigger)
    else $error("adc trigger missing on compare match");

  a_trig_quiet: assert property (
    i_ce && !i_local_timebase |=> !o_adc_trigger)
    else $error("adc trigger raised outside local time base");

  a_trig_miss: assert property (
    i_ce && i_timebase_count != trigger_match_value |=> !o_adc_trigger)
    else $error("adc trigger raised without compare match");

  a_direct_route: assert property (
    i_ce && !fault_act && !limit_act && !ovr_live_reg.high_en &&
    !pin_ctrl_reg.swap
    |=> o_high_side_output ==
        ($past(i_gen_high) ^ $past(pin_ctrl_reg.high_pin_polarity)))
    else $error("high signal not on its own pin");

  a_swap_low: assert property (
    i_ce && !fault_act && !limit_act && !ovr_live_reg.low_en &&
    pin_ctrl_reg.swap
    |=> o_low_side_output ==
        ($past(i_gen_high) ^ $past(pin_ctrl_reg.low_pin_polarity)))
    else $error("exchanged high signal missing on low pin");

  a_limit_high: assert property (
    i_ce && limit_act && !fault_act &&
    !fault_ctrl_reg.independent_fault_select
    |=> o_high_side_output ==
        ($past(pin_ctrl_reg.limit_state_bits[1]) ^
         $past(pin_ctrl_reg.high_pin_polarity)))
    else $error("limit state not on high pin");

  a_fault_low: assert property (
    i_ce && fault_act && !fault_ctrl_reg.independent_fault_select
    |=> o_low_side_output ==
        ($past(pin_ctrl_reg.fault_state_bits[0]) ^
         $past(pin_ctrl_reg.low_pin_polarity)))
    else $error("fault state not on low pin");

  a_fault_over_limit: assert property (
    i_ce && fault_act && limit_act &&
    !fault_ctrl_reg.independent_fault_select
    |=> o_low_side_output ==
        ($past(pin_ctrl_reg.fault_state_bits[0]) ^
         $past(pin_ctrl_reg.low_pin_polarity)))
    else $error("limit state beat fault state");

  a_fault_over_ovr: assert property (
    i_ce && fault_act && ovr_live_reg.high_en &&
    !fault_ctrl_reg.independent_fault_select
    |=> o_high_side_output ==
        ($past(pin_ctrl_reg.fault_state_bits[1]) ^
         $past(pin_ctrl_reg.high_pin_polarity)))
    else $error("override beat fault state");

  a_indep_fault: assert property (
    i_ce && fault_act && fault_ctrl_reg.independent_fault_select
    |=> o_low_side_output ==
        ($past(pin_ctrl_reg.fault_state_bits[0]) ^
         $past(pin_ctrl_reg.low_pin_polarity)))
    else $error("independent fault did not force low pin");

  a_override_high: assert property (
    i_ce && ovr_live_reg.high_en && !fault_act && !limit_act
    |=> o_high_side_output ==
        ($past(ovr_live_reg.level[1]) ^
         $past(pin_ctrl_reg.high_pin_polarity)))
    else $error("override level not on high pin");

  a_override_en_now: assert property (
    i_ce && !pin_ctrl_reg.override_sync_select
    |=> ovr_live_reg.high_en == $past(pin_ctrl_reg.high_override_enable))
    else $error("unsynced override enable not applied next clock");

  a_fault_src_off: assert property (
    i_ce && fault_ctrl_reg.fault_source_select == `PFS_SRC_RESERVED
    |=> !o_fault_active)
    else $error("reserved fault source raised a fault");

  a_limit_src_off: assert property (
    i_ce && fault_ctrl_reg.limit_source_select == `PFS_SRC_RESERVED
    |=> !o_limit_active)
    else $error("reserved limit source raised a limit");

  c_fault_hit:  cover property (i_ce && fault_act && limit_act);
  c_swap_run:   cover property (i_ce && pin_ctrl_reg.swap && i_gen_high);
  c_sync_apply: cover property (
    i_ce && pin_ctrl_reg.override_sync_select && i_period_start);
  c_trigger:    cover property (o_adc_trigger);
  c_indep_limit: cover property (
    i_ce && fault_ctrl_reg.independent_fault_select && limit_act);

endmodule

// ===== tb/pwm_source_model.sv
/*
  Far-side model: comparator and fault source lines seen by the
  steering stage. The bench picks which source index is asserted.
  Assumes one clock; lines are plain active-high levels.
*/
`timescale 1ns/1ps

module pwm_source_model #(
  parameter int SRC_N = 32
) (
  // Source selection from the bench
  input  wire logic [4:0]       i_fault_idx,
  input  wire logic             i_fault_on,
  input  wire logic [4:0]       i_limit_idx,
  input  wire logic             i_limit_on,
  // Lines toward the steering stage
  output logic [SRC_N-1:0]      o_ctrl_src
);
  always_comb begin
    o_ctrl_src = '0;
    if (i_fault_on) begin
      o_ctrl_src[i_fault_idx] = 1'b1;
    end
    if (i_limit_on) begin
      o_ctrl_src[i_limit_idx] = 1'b1;
    end
  end
endmodule

// ===== tb/pwm_output_fault_steering_tb_top.sv
/*
  Self-checking bench for the output steering stage: register
  access, trigger compare, exchange, override, limit and fault.
  Assumes a 10 MHz clock and the source model beside the design.
*/
`timescale 1ns/1ps
`include "pwm_fault_steer_params.svh"

module pwm_output_fault_steering_tb_top;
  import pwm_fault_steer_pkg::*;
  logic                   clk, resetn, gen_h, gen_l, per_st, loc_tb, m_en;
  logic [`PFS_TRIG_W-1:0] tb_cnt;
  logic [`PFS_DATA_W-1:0] rdata;
  logic [31:0]            src;
  logic [4:0]             f_idx, l_idx;
  logic                   f_on, l_on, p_h, p_l, own_h, own_l, trig, f_act;
  logic                   l_act, ce;
  reg_req_s               req;
  int                     mismatches, checked;

  pwm_output_fault_steering #(.SRC_N(32)) DUT (
    .i_clk(clk), .i_resetn(resetn), .i_ce(ce), .i_req(req),
    .o_rdata(rdata), .i_gen_high(gen_h), .i_gen_low(gen_l),
    .i_period_start(per_st), .i_local_timebase(loc_tb),
    .i_timebase_count(tb_cnt), .i_module_enable(m_en),
    .i_ctrl_src(src), .o_high_side_output(p_h),
    .o_low_side_output(p_l), .o_high_owned(own_h),
    .o_low_owned(own_l), .o_adc_trigger(trig),
    .o_fault_active(f_act), .o_limit_active(l_act));

  pwm_source_model #(.SRC_N(32)) far_side (
    .i_fault_idx(f_idx), .i_fault_on(f_on), .i_limit_idx(l_idx),
    .i_limit_on(l_on), .o_ctrl_src(src));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic print_verdict();
    if (mismatches == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pins(input logic h, input logic l);
    checked++;
    if (p_h !== h || p_l !== l) begin
      mismatches++;
      $display("[FAIL] %0t pins %b%b expected %b%b", $time, p_h, p_l, h, l);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [1:0] a, input logic [15:0] exp);
    @(posedge clk);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    chk_word(rdata, exp);
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic srcs(input logic f, input logic l);
    @(posedge clk);
    f_on <= f;
    l_on <= l;
    settle();
  endtask

  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    req = '0;
    gen_h = 1'b0;
    gen_l = 1'b0;
    per_st = 1'b0;
    loc_tb = 1'b0;
    m_en = 1'b0;
    tb_cnt = 13'h0000;
    f_idx = 5'h02;
    l_idx = 5'h01;
    f_on = 1'b0;
    l_on = 1'b0;
    mismatches = 0;
    checked = 0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    chk_word({14'h0000, own_h, own_l}, 16'h0003);
    rd_chk(2'h0, 16'hc000);
    rd_chk(2'h1, 16'h0000);
    rd_chk(2'h2, 16'h00f8);
    rd_chk(2'h3, 16'h0000);
    wr(2'h1, 16'hffff);
    rd_chk(2'h1, 16'hfff8);
    wr(2'h1, 16'h002f);
    @(posedge clk);
    loc_tb <= 1'b1;
    m_en <= 1'b1;
    tb_cnt <= 13'h0005;
    @(posedge clk);
    #1;
    chk_word({15'h0000, trig}, 16'h0001);
    @(posedge clk);
    loc_tb <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk_word({15'h0000, trig}, 16'h0000);
    // Pair mode stays 00 from here on, as the module is now enabled
    for (int s = 0; s < 2; s++) begin
      wr(2'h0, 16'hc000 | 16'(s << 1));
      @(posedge clk);
      gen_h <= 1'b1;
      gen_l <= 1'b0;
      settle();
      chk_pins(s == 0, s == 1);
    end
    wr(2'h0, 16'hf000);
    settle();
    chk_pins(1'b0, 1'b1);
    @(posedge clk);
    gen_h <= 1'b0;
    wr(2'h0, 16'hc380);
    settle();
    chk_pins(1'b1, 1'b0);
    wr(2'h0, 16'hc341);
    repeat (4) @(posedge clk);
    #1;
    chk_pins(1'b1, 1'b0);
    @(posedge clk);
    per_st <= 1'b1;
    @(posedge clk);
    per_st <= 1'b0;
    settle();
    chk_pins(1'b0, 1'b1);
    wr(2'h0, 16'hc3d8);
    wr(2'h2, 16'h05fb);
    srcs(1'b0, 1'b1);
    chk_pins(1'b1, 1'b0);
    chk_word({15'h0000, l_act}, 16'h0001);
    wr(2'h2, 16'h0510);
    srcs(1'b1, 1'b1);
    chk_pins(1'b0, 1'b1);
    chk_word({15'h0000, f_act}, 16'h0001);
    wr(2'h0, 16'hf018);
    srcs(1'b0, 1'b1);
    chk_pins(1'b0, 1'b1);
    wr(2'h0, 16'hc018);
    wr(2'h2, 16'h8510);
    @(posedge clk);
    gen_h <= 1'b1;
    gen_l <= 1'b1;
    settle();
    chk_pins(1'b0, 1'b1);
    srcs(1'b1, 1'b0);
    chk_pins(1'b1, 1'b1);
    @(posedge clk);
    gen_l <= 1'b0;
    settle();
    chk_pins(1'b1, 1'b1);
    wr(2'h2, 16'h7df8);
    @(posedge clk);
    f_idx <= 5'h1f;
    l_idx <= 5'h1f;
    srcs(1'b1, 1'b0);
    chk_pins(1'b1, 1'b0);
    chk_word({15'h0000, f_act}, 16'h0000);
    chk_word({15'h0000, l_act}, 16'h0000);
    // Inverted fault input: a quiet source line reads as a fault
    wr(2'h2, 16'h0004);
    settle();
    chk_pins(1'b0, 1'b1);
    chk_word({15'h0000, f_act}, 16'h0001);
    // Strobes are ignored while the clock enable is low
    @(posedge clk);
    ce <= 1'b0;
    wr(2'h1, 16'h0008);
    @(posedge clk);
    ce <= 1'b1;
    rd_chk(2'h1, 16'h0028);
    print_verdict();
  end

  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    print_verdict();
  end
endmodule
